// ===== src/adcsq_sequencer.sv
`timescale 1ns/1ps
module adcsq_sequencer #(
  parameter int unsigned DIV_SEL_BITS = 3
) (
  input  wire logic                 clk_i,                   // System clock, 20 MHz
  input  wire logic                 rst_n_i,                 // Sync reset, active low
  input  wire logic [7:0]           conv_control_first_i,    // First control register value
  input  wire logic [2:0]           conv_clock_select_i,     // Divider select, fsys/2^n
  input  wire logic [1:0]           reference_select_i,      // Reference source code
  input  wire logic [2:0]           internal_source_select_i,// Internal source code
  input  wire logic                 start_i,                 // Start bit level
  input  wire logic                 global_irq_enable_i,     // Global interrupt enable
  input  wire logic                 conv_irq_enable_i,       // Converter interrupt enable
  input  wire logic                 conv_irq_request_clr_i,  // Software clears request flag
  input  wire logic                 comparator_i,            // Analog compare, 1 = input above DAC
  output logic                      conv_power_o,            // Analog power enable
  output logic                      sample_o,                // Track/hold switch closed
  output logic [11:0]               trial_code_o,            // Code driven to the internal DAC
  output adcsq_pkg::adcsq_route_t   route_o,                 // Analog routing selects
  output logic                      conv_busy_flag_o,        // Conversion in progress
  output logic                      conv_irq_request_o,      // Sticky completion flag
  output logic                      irq_o,                   // Completion interrupt
  output adcsq_pkg::adcsq_result_t  result_o                 // Result register pair
);
  if (DIV_SEL_BITS != adcsq_pkg::SEL_BITS) begin : g_chk
    $error("Divider select width must match the register field");
  end

  logic                   power_on;
  logic                   result_format;
  logic [3:0]             chan;
  adcsq_pkg::adcsq_state_t state_ff;
  adcsq_pkg::adcsq_state_t nxt_state;
  logic [6:0]             div_cnt_ff;
  logic                   tick;
  logic [3:0]             phase_cnt_ff;
  logic [3:0]             bit_idx_ff;
  logic [11:0]            sar_ff;
  logic                   start_d_ff;
  logic                   start_rise;
  logic                   start_fall;
  logic                   done;
  logic                   irq_req_ff;
  logic [11:0]            res_ff;
  logic                   fmt_ff;

  // Field decode of the first control register
  assign power_on      = conv_control_first_i[adcsq_pkg::POWER_BIT_POS];
  assign result_format = conv_control_first_i[adcsq_pkg::FORMAT_BIT_POS];
  assign chan = conv_control_first_i[adcsq_pkg::CHAN_LSB_POS +: adcsq_pkg::CHAN_BITS];

  // Power follows the enable bit only; no sequencing can keep it on
  assign conv_power_o = power_on;

  // Routing; the external path is on only for channel codes below the unused range
  always_comb begin
    route_o              = '0;
    route_o.supply_ref   = power_on && (reference_select_i == adcsq_pkg::REF_SUPPLY);
    route_o.dac_ref      = power_on && (reference_select_i == adcsq_pkg::REF_DAC);
    route_o.ext_ref      = power_on && ((reference_select_i == adcsq_pkg::REF_EXT_A) ||
                                        (reference_select_i == adcsq_pkg::REF_EXT_B));
    route_o.ext_path_on  = power_on && (chan < adcsq_pkg::CHAN_FIRST_UNUSED);
    route_o.ext_channel  = chan;
    route_o.internal_src = power_on ? internal_source_select_i : 3'h0;
  end

  // Start bit edges; start comes from the CPU on the same clock
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      start_d_ff <= 1'b0;
    end else begin
      start_d_ff <= start_i;
    end
  end
  assign start_rise = start_i && !start_d_ff;
  assign start_fall = !start_i && start_d_ff;

  // Converter clock divider, restarted with each conversion so phases align
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state_ff == adcsq_pkg::ADCSQ_IDLE || state_ff == adcsq_pkg::ADCSQ_ARMED) begin
      div_cnt_ff <= 7'h00;
    end else begin
      div_cnt_ff <= tick ? 7'h00 : div_cnt_ff + 7'h01;
    end
  end
  assign tick = (div_cnt_ff == 7'((8'h01 << conv_clock_select_i) - 8'h01));

  // Sequencer; runs without any help from software once started
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      adcsq_pkg::ADCSQ_IDLE:   if (power_on && start_i) nxt_state = adcsq_pkg::ADCSQ_ARMED;
      adcsq_pkg::ADCSQ_ARMED:  if (start_fall) nxt_state = adcsq_pkg::ADCSQ_SAMPLE;
      adcsq_pkg::ADCSQ_SAMPLE: if (tick && phase_cnt_ff == 4'(adcsq_pkg::SAMPLE_PERIODS - 1))
                                 nxt_state = adcsq_pkg::ADCSQ_CONV;
      adcsq_pkg::ADCSQ_CONV:   if (done) nxt_state = adcsq_pkg::ADCSQ_IDLE;
    endcase
    if (start_rise) nxt_state = adcsq_pkg::ADCSQ_ARMED;
    if (!power_on) nxt_state = adcsq_pkg::ADCSQ_IDLE;
  end
  assign done = (state_ff == adcsq_pkg::ADCSQ_CONV) && tick &&
                (phase_cnt_ff == 4'(adcsq_pkg::CONVERT_PERIODS - 1)) && !start_rise && power_on;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= adcsq_pkg::ADCSQ_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Phase counter counts converter clock periods inside each phase
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || nxt_state != state_ff) begin
      phase_cnt_ff <= 4'h0;
    end else if (tick) begin
      phase_cnt_ff <= phase_cnt_ff + 4'h1;
    end
  end

  // Successive approximation, MSB first, one bit per converter period
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state_ff != adcsq_pkg::ADCSQ_CONV) begin
      sar_ff     <= 12'h800;
      bit_idx_ff <= 4'hb;
    end else if (tick) begin
      sar_ff[bit_idx_ff] <= comparator_i;
      if (bit_idx_ff != 4'h0) begin
        sar_ff[bit_idx_ff - 4'h1] <= 1'b1;
        bit_idx_ff <= bit_idx_ff - 4'h1;
      end
    end
  end
  assign trial_code_o = sar_ff;
  assign sample_o     = (state_ff == adcsq_pkg::ADCSQ_SAMPLE);

  // Result capture; full scale leaves every trial bit set, giving all ones
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      res_ff <= 12'h000;
      fmt_ff <= 1'b0;
    end else if (done) begin
      res_ff <= {sar_ff[11:1], comparator_i};
      fmt_ff <= result_format;
    end
  end

  // Format bit chooses left or right alignment across the pair
  always_comb begin
    if (fmt_ff) begin
      result_o = {4'h0, res_ff};
    end else begin
      result_o = {res_ff, 4'h0};
    end
  end

  // Busy covers the armed phase too, so a poll never sees stale done
  assign conv_busy_flag_o = (state_ff != adcsq_pkg::ADCSQ_IDLE);

  // Request flag; a completion in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_req_ff <= 1'b0;
    end else if (done) begin
      irq_req_ff <= 1'b1;
    end else if (conv_irq_request_clr_i) begin
      irq_req_ff <= 1'b0;
    end
  end
  assign conv_irq_request_o = irq_req_ff;
  assign irq_o = irq_req_ff && global_irq_enable_i && conv_irq_enable_i;

  // Checks; the phase length checks hold for divider select 0 only and stand down while start is high or power is off,
  // since an abort or a divider change legally cuts a phase short
  busy_fall_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(conv_busy_flag_o) && power_on && !$past(start_rise) |-> irq_req_ff)
    else $error("Busy fell without request flag");
  power_off_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !power_on |=> !conv_busy_flag_o)
    else $error("Busy while powered down");
  power_dark_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !conv_power_o |-> route_o.internal_src == 3'h0 && !route_o.ext_path_on &&
      !route_o.supply_ref && !route_o.dac_ref && !route_o.ext_ref)
    else $error("Analog routing live while powered down");
  irq_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_o |-> global_irq_enable_i && conv_irq_enable_i && conv_irq_request_o)
    else $error("Interrupt without both enables");
  start_arms_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start_rise && power_on |=> state_ff == adcsq_pkg::ADCSQ_ARMED)
    else $error("Start rise did not rearm");
  fall_starts_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_ff == adcsq_pkg::ADCSQ_ARMED && start_fall && power_on
      |=> state_ff == adcsq_pkg::ADCSQ_SAMPLE)
    else $error("Falling start did not begin sampling");
  sample_len_a: assert property (@(posedge clk_i)
    disable iff (!rst_n_i || start_i || !power_on || conv_clock_select_i != 3'h0)
    $rose(sample_o) |-> sample_o [*4] ##1 state_ff == adcsq_pkg::ADCSQ_CONV)
    else $error("Sampling not four periods");
  conv_len_a: assert property (@(posedge clk_i)
    disable iff (!rst_n_i || start_i || !power_on || conv_clock_select_i != 3'h0)
    $rose(state_ff == adcsq_pkg::ADCSQ_CONV)
      |-> ##11 conv_busy_flag_o ##1 !conv_busy_flag_o)
    else $error("Conversion not twelve periods");
  busy_during_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sample_o |-> conv_busy_flag_o)
    else $error("Not busy while sampling");
  full_scale_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done && sar_ff[11:1] == 11'h7ff && comparator_i
      |=> res_ff == adcsq_pkg::FULL_SCALE_CODE)
    else $error("Full scale not all ones");
  cov_done_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) done);
  cov_abort_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    state_ff == adcsq_pkg::ADCSQ_CONV && start_rise);
  cov_irq_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(irq_o));
  cov_off_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    sample_o && !power_on);
endmodule

// ===== src/adcsq_pkg.sv
package adcsq_pkg;
  // Conversion phases in converter clock periods
  localparam int unsigned SAMPLE_PERIODS  = 4;
  localparam int unsigned CONVERT_PERIODS = 12;
  localparam int unsigned RESULT_BITS     = 12;
  localparam int unsigned SEL_BITS        = 3;
  localparam logic [11:0] FULL_SCALE_CODE = 12'hfff;

  // First control register layout: power bit, format bit, channel field
  localparam logic [7:0] CTRL_FIRST_RESET = 8'h00;
  localparam int unsigned POWER_BIT_POS    = 5;
  localparam int unsigned FORMAT_BIT_POS   = 4;
  localparam int unsigned CHAN_LSB_POS     = 0;
  localparam int unsigned CHAN_BITS        = 4;
  localparam logic [3:0] CHAN_FIRST_UNUSED = 4'h4;

  // Reference select codes
  localparam logic [1:0] REF_EXT_A  = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_DAC    = 2'h2;
  localparam logic [1:0] REF_EXT_B  = 2'h3;

  typedef enum logic [1:0] {
    ADCSQ_IDLE   = 2'b00,
    ADCSQ_ARMED  = 2'b01,
    ADCSQ_SAMPLE = 2'b10,
    ADCSQ_CONV   = 2'b11
  } adcsq_state_t;

  // Analog routing toward the converter front end; at most one reference select is set
  typedef struct packed {
    logic       supply_ref;
    logic       dac_ref;
    logic       ext_ref;
    logic       ext_path_on;
    logic [3:0] ext_channel;
    logic [2:0] internal_src;
  } adcsq_route_t;

  // Result pair as read by software
  typedef struct packed {
    logic [7:0] result_high;
    logic [7:0] result_low;
  } adcsq_result_t;
endpackage

// ===== dv/adcsq_sequencer_tb.sv
`timescale 1ns/1ps
module adcsq_sequencer_tb;
  logic                     clk_i, rst_n_i, start_i, ge, ce, clr, cmp;
  logic [7:0]               ctrl;
  logic [2:0]               csel, isrc;
  logic [1:0]               rsel;
  logic [11:0]              target, trial;
  logic                     power, sample, busy, req, irq;
  logic [15:0]              last;
  adcsq_pkg::adcsq_route_t  route;
  adcsq_pkg::adcsq_result_t result;
  int                       n_mismatch, cmp_count, cnt_s, cnt_c;

  adcsq_sequencer i_adcsq_sequencer (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .conv_control_first_i(ctrl),
    .conv_clock_select_i(csel), .reference_select_i(rsel), .internal_source_select_i(isrc),
    .start_i(start_i), .global_irq_enable_i(ge), .conv_irq_enable_i(ce),
    .conv_irq_request_clr_i(clr), .comparator_i(cmp), .conv_power_o(power),
    .sample_o(sample), .trial_code_o(trial), .route_o(route), .conv_busy_flag_o(busy),
    .conv_irq_request_o(req), .irq_o(irq), .result_o(result));

  // 50 ns system clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Ideal analog input: keep a trial bit while the input is not below it
  always @(posedge clk_i) begin
    #2;
    cmp = (target >= trial);
  end

  task automatic step(int k = 1);
    repeat (k) @(posedge clk_i);
    #2;
  endtask

  task automatic chk_bit(logic got, logic exp, string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(logic [15:0] got, logic [15:0] exp, string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Start pulse: high arms and resets, low lets the conversion run
  task automatic launch();
    start_i = 1'b1;
    step();
    chk_bit(busy, 1'b1, "busy after start");
    start_i = 1'b0;
  endtask

  // Follows one conversion to its end, counting sample and convert cycles
  task automatic finish(logic [2:0] n, logic fmt, logic [11:0] tgt);
    cnt_s = 0;
    cnt_c = 0;
    for (int k = 0; k < 5000 && busy === 1'b1; k++) begin
      if (req !== 1'b0) chk_bit(req, 1'b0, "flag early");
      step();
      if (sample === 1'b1) cnt_s++;
      else if (busy === 1'b1 && cnt_s > 0) cnt_c++;
    end
    chk_word(16'(cnt_s), 16'(4 << n), "sample cycles");
    chk_word(16'(cnt_c), 16'(12 << n), "convert cycles");
    chk_bit(req, 1'b1, "flag at completion");
    chk_word(result, fmt ? {4'h0, tgt} : {tgt, 4'h0}, "result");
    chk_bit(irq, ge & ce, "interrupt");
  endtask

  task automatic clear_flag();
    clr = 1'b1;
    step();
    clr = 1'b0;
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Whole test is a few hundred cycles; allow generous margin
  initial begin
    #(50 * 20000);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    // The comparator input is driven by the analog model process only
    rst_n_i = 1'b0;
    start_i = 1'b0;
    ge = 1'b0;
    ce = 1'b0;
    clr = 1'b0;
    ctrl = 8'h00;
    csel = 3'h0;
    isrc = 3'h0;
    rsel = 2'h0;
    target = 12'h000;
    step(5);
    rst_n_i = 1'b1;
    chk_word({busy, req, 14'h0}, 16'h0000, "reset flags");
    chk_word(result, 16'h0000, "reset result");
    chk_word({4'h0, trial}, 16'h0800, "reset trial");
    $display("test reset done");
    // Power off: start ignored, analog side dark
    start_i = 1'b1;
    step();
    start_i = 1'b0;
    step(3);
    chk_bit(busy, 1'b0, "start unpowered");
    chk_bit(power, 1'b0, "power off");
    chk_word({12'h0, route.supply_ref, route.dac_ref, route.ext_ref, route.ext_path_on},
             16'h0000, "routing off");
    $display("test power off done");
    // Typical setup value, then every reference code
    ctrl = 8'h20;
    step();
    chk_bit(power, 1'b1, "power on");
    chk_word({route.ext_path_on, 11'h0, route.ext_channel}, 16'h8000, "channel zero");
    for (int r = 0; r < 4; r++) begin
      rsel = 2'(r);
      step();
      chk_word({route.supply_ref, route.dac_ref, route.ext_ref},
               {r == 1, r == 2, r == 0 || r == 3}, "reference");
    end
    // Park the channel in the unused range first, then pick the internal source
    ctrl = 8'h25;
    step();
    isrc = 3'h2;
    step();
    chk_bit(route.ext_path_on, 1'b0, "unused channel");
    chk_word({13'h0, route.internal_src}, 16'h0002, "internal source");
    $display("test routing done");
    // Divider selects 0 to 3, both formats, every enable pair, full scale and zero codes
    for (int n = 0; n < 4; n++) begin
      clear_flag();
      ge = n[0];
      ce = n[1];
      csel = 3'(n);
      target = (n == 0) ? 12'hfff : (n == 1) ? 12'h000 : (n == 2) ? 12'ha5c : 12'h5a3;
      ctrl = {2'b00, 1'b1, n[0], 4'h0};
      step();
      launch();
      finish(3'(n), n[0], target);
    end
    clear_flag();
    chk_bit(req, 1'b0, "flag cleared");
    chk_bit(irq, 1'b0, "interrupt cleared");
    $display("test dividers done");
    // Restart in mid-conversion runs a full new conversion
    csel = 3'h1;
    target = 12'h3c7;
    step();
    launch();
    step(12);
    launch();
    finish(3'h1, 1'b1, 12'h3c7);
    clear_flag();
    $display("test restart done");
    // Power lost during sampling: no flag, old result kept
    last = result;
    target = 12'h111;
    launch();
    step(8);
    ctrl = 8'h00;
    step(2);
    chk_bit(busy, 1'b0, "busy after power loss");
    chk_bit(req, 1'b0, "flag after power loss");
    chk_word(result, last, "result kept");
    $display("test power loss done");
    complete_run();
  end
endmodule
